// [verilog/cic_top.sv]
// Purpose: interrupt control of an 8-bit cpu core, with apb register access
// Assumes: one 10 MHz clock; q phases come from a 4-phase enable counter
// Notes:   the core supplies its live registers, pc and instruction events
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module cic_top
   import cic_pkg::*;
#(
   parameter int PFLAGS = 8
) (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   // event sources
   input  wire logic        i_timer0_ovf,
   input  wire logic        i_ext_pin,
   input  wire logic [7:0]  i_pin_change_flags,
   input  wire logic [7:0]  i_periph_events,
   input  wire logic [7:0]  i_periph_wake_capable,
   input  wire logic        i_pin_change_async,
   // core interface
   input  wire logic        i_instr_done,
   input  wire logic        i_sleeping,
   input  wire logic        i_return_from_interrupt,
   input  wire logic [7:0]  i_live_w,
   input  wire logic [7:0]  i_live_status,
   input  wire logic [7:0]  i_live_bsr,
   input  wire logic [15:0] i_live_fsr0,
   input  wire logic [15:0] i_live_fsr1,
   input  wire logic [7:0]  i_live_pc_high_latch,
   output logic             o_q_phase1,
   output logic             o_flush,
   output logic             o_push_pc,
   output logic             o_pop_pc,
   output logic             o_load_vector,
   output logic [15:0]      o_vector,
   output logic             o_restore,
   output logic [7:0]       o_shadow_w,
   output logic [7:0]       o_shadow_status,
   output logic [7:0]       o_shadow_bsr,
   output logic [15:0]      o_shadow_fsr0,
   output logic [15:0]      o_shadow_fsr1,
   output logic [7:0]       o_shadow_pc_high_latch,
   output logic [4:0]       o_shadow_bank,
   output logic             o_wake,
   output logic             o_irq_pending
);

   initial begin
      if (PFLAGS != 8) $error("cic_top: PFLAGS must be 8");
   end

   typedef enum {
      CIC_RUN,
      CIC_WAIT1,
      CIC_WAIT2,
      CIC_WAKE_STEP
   } cic_state_t;

   typedef struct packed {
      logic [7:0]  core;
      logic [7:0]  peripheral_enable_one;
      logic [7:0]  pflag;
      logic        edge_sel;
      logic        pin_q;
      logic [1:0]  qcnt;
      cic_state_t  st;
      logic [7:0]  sh_w;
      logic [7:0]  sh_st;
      logic [7:0]  sh_bsr;
      logic [15:0] sh_f0;
      logic [15:0] sh_f1;
      logic [7:0]  sh_pcl;
      logic        flush;
      logic        push;
      logic        vect;
      logic        pop;
      logic        rest;
      logic        wake;
      logic [31:0] rdata;
   } cic_regs_t;

   cic_regs_t r;
   cic_regs_t next_r;

   logic       wr;
   logic       rd;
   logic [7:0] wd;
   logic       pin_edge;
   logic       core_req;
   logic       periph_req;
   logic       req;
   logic       wake_src;
   logic       q_edge_ok;

   // apb takes every access in its first access cycle
   assign wr        = i_psel & i_penable & i_pwrite;
   assign rd        = i_psel & i_penable & ~i_pwrite;
   assign wd        = i_pwdata[7:0];
   assign o_pready  = 1'b1;
   assign o_pslverr = 1'b0;

   // pin edge qualified by the select bit; q4 and q1 are both open
   assign q_edge_ok = (r.qcnt == 2'd3) || (r.qcnt == 2'd0);
   assign pin_edge  = r.edge_sel ? (i_ext_pin & ~r.pin_q)
                                 : (~i_ext_pin & r.pin_q);

   // request tree; global enable gating is applied only for vectoring and o_irq_pending
   assign core_req   = (r.core[CIC_B_T0IE] & r.core[CIC_B_T0IF])
                     | (r.core[CIC_B_EXIE] & r.core[CIC_B_EXIF])
                     | (r.core[CIC_B_PCIE] & r.core[CIC_B_PCIF]);
   assign periph_req = r.core[CIC_B_PERIPH_GROUP_ENABLE] & |(r.peripheral_enable_one & r.pflag);
   assign req        = core_req | periph_req;
   // wake only from sources that run without the clock
   assign wake_src   = (r.core[CIC_B_EXIE] & r.core[CIC_B_EXIF])
                     | (i_pin_change_async & r.core[CIC_B_PCIE] & r.core[CIC_B_PCIF])
                     | (r.core[CIC_B_PERIPH_GROUP_ENABLE]
                        & |(r.peripheral_enable_one & r.pflag & i_periph_wake_capable));

   // single next-state process for the whole block
   always_comb begin
      next_r       = r;
      next_r.flush = 1'b0;
      next_r.push  = 1'b0;
      next_r.vect  = 1'b0;
      next_r.pop   = 1'b0;
      next_r.rest  = 1'b0;
      next_r.wake  = 1'b0;
      next_r.qcnt  = r.qcnt + 2'd1;
      next_r.pin_q = i_ext_pin;

      // register writes first, so hardware sets below win over clears
      if (wr) begin
         case (i_paddr)
            CIC_OFS_CORE:   next_r.core[7:1] = wd[7:1];
            CIC_OFS_PERIPHERAL_ENABLE_ONE:   next_r.peripheral_enable_one      = wd;
            CIC_OFS_PFLAG:  next_r.pflag     = wd;
            CIC_OFS_OPTION: next_r.edge_sel  = wd[0];
            CIC_OFS_SH_W:   next_r.sh_w      = wd;
            CIC_OFS_SH_ST:  next_r.sh_st     = wd & ~CIC_ST_KEEP_MASK;
            CIC_OFS_SH_BSR: next_r.sh_bsr    = wd;
            CIC_OFS_SH_F0L: next_r.sh_f0[7:0]  = wd;
            CIC_OFS_SH_F0H: next_r.sh_f0[15:8] = wd;
            CIC_OFS_SH_F1L: next_r.sh_f1[7:0]  = wd;
            CIC_OFS_SH_F1H: next_r.sh_f1[15:8] = wd;
            CIC_OFS_SH_PCL: next_r.sh_pcl    = wd;
            default: ;
         endcase
      end

      // flags set regardless of any enable
      if (i_timer0_ovf) next_r.core[CIC_B_T0IF] = 1'b1;
      if (pin_edge && q_edge_ok) next_r.core[CIC_B_EXIF] = 1'b1;
      else if (pin_edge) next_r.core[CIC_B_EXIF] = 1'b1;
      next_r.pflag = next_r.pflag | i_periph_events;
      // summary flag follows the individual pin-change flags only
      next_r.core[CIC_B_PCIF] = |i_pin_change_flags;

      case (r.st)
         CIC_RUN: begin
            if (i_sleeping && wake_src) begin
               next_r.wake = 1'b1;
               next_r.st   = CIC_WAKE_STEP;
            end else if (i_return_from_interrupt) begin
               next_r.pop  = 1'b1;
               next_r.rest = 1'b1;
               next_r.core[CIC_B_GIE] = 1'b1;
            end else if (i_instr_done && r.core[CIC_B_GIE] && req) begin
               // entry at instruction boundary: latency 3 or 4 cycles
               next_r.flush = 1'b1;
               next_r.push  = 1'b1;
               next_r.core[CIC_B_GIE] = 1'b0;
               next_r.sh_w   = i_live_w;
               next_r.sh_st  = i_live_status & ~CIC_ST_KEEP_MASK;
               next_r.sh_bsr = i_live_bsr;
               next_r.sh_f0  = i_live_fsr0;
               next_r.sh_f1  = i_live_fsr1;
               next_r.sh_pcl = i_live_pc_high_latch;
               next_r.st     = CIC_WAIT1;
            end
            // with global enable clear, flags just wait
         end
         CIC_WAIT1: begin
            if (i_instr_done) next_r.st = CIC_WAIT2;               // forced nop cycle
         end
         CIC_WAIT2: begin
            if (i_instr_done) begin
               next_r.vect = 1'b1;
               next_r.st   = CIC_RUN;
            end
         end
         CIC_WAKE_STEP: begin
            // the instruction after sleep completes before any vectoring
            if (i_instr_done) next_r.st = CIC_RUN;
         end
         default: next_r.st = CIC_RUN;
      endcase

      // read data captured for the access cycle
      next_r.rdata = 32'h0000_0000;
      if (rd || (i_psel && !i_penable)) begin
         case (i_paddr)
            CIC_OFS_CORE:   next_r.rdata[7:0] = r.core;
            CIC_OFS_PERIPHERAL_ENABLE_ONE:   next_r.rdata[7:0] = r.peripheral_enable_one;
            CIC_OFS_PFLAG:  next_r.rdata[7:0] = r.pflag;
            CIC_OFS_OPTION: next_r.rdata[0]   = r.edge_sel;
            CIC_OFS_SH_W:   next_r.rdata[7:0] = r.sh_w;
            CIC_OFS_SH_ST:  next_r.rdata[7:0] = r.sh_st;
            CIC_OFS_SH_BSR: next_r.rdata[7:0] = r.sh_bsr;
            CIC_OFS_SH_F0L: next_r.rdata[7:0] = r.sh_f0[7:0];
            CIC_OFS_SH_F0H: next_r.rdata[7:0] = r.sh_f0[15:8];
            CIC_OFS_SH_F1L: next_r.rdata[7:0] = r.sh_f1[7:0];
            CIC_OFS_SH_F1H: next_r.rdata[7:0] = r.sh_f1[15:8];
            CIC_OFS_SH_PCL: next_r.rdata[7:0] = r.sh_pcl;
            CIC_OFS_STATE:  next_r.rdata[1:0] = r.st[1:0];
            default:        next_r.rdata      = 32'h0000_0000;
         endcase
      end
   end

   // one register for all state; every enable clears on reset
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         r      <= '0;
         r.st   <= CIC_RUN;
      end else begin
         r <= next_r;
      end
   end

   // outputs from flip-flops, except the decoded q phase and irq pending and the constant vector and bank
   assign o_prdata        = r.rdata;
   assign o_q_phase1      = (r.qcnt == 2'd0);
   assign o_flush         = r.flush;
   assign o_push_pc       = r.push;
   assign o_pop_pc        = r.pop;
   assign o_load_vector   = r.vect;
   assign o_vector        = CIC_VECTOR;
   assign o_restore       = r.rest;
   assign o_shadow_w      = r.sh_w;
   assign o_shadow_status = r.sh_st;
   assign o_shadow_bsr    = r.sh_bsr;
   assign o_shadow_fsr0   = r.sh_f0;
   assign o_shadow_fsr1   = r.sh_f1;
   assign o_shadow_pc_high_latch = r.sh_pcl;
   assign o_shadow_bank   = CIC_SHADOW_BANK;
   assign o_wake          = r.wake;
   assign o_irq_pending   = req & r.core[CIC_B_GIE];

endmodule

// [verilog/cic_pkg.sv]
// Purpose: constants for the cpu interrupt controller
// Assumes: apb register access, 32-bit data, 8-bit registers in low bits
// Notes:   one aligned word per register
package cic_pkg;
   // register byte addresses
   localparam logic [7:0] CIC_OFS_CORE   = 8'h00;
   localparam logic [7:0] CIC_OFS_PERIPHERAL_ENABLE_ONE   = 8'h04;
   localparam logic [7:0] CIC_OFS_PFLAG  = 8'h08;
   localparam logic [7:0] CIC_OFS_OPTION = 8'h0C;
   localparam logic [7:0] CIC_OFS_SH_W   = 8'h10;
   localparam logic [7:0] CIC_OFS_SH_ST  = 8'h14;
   localparam logic [7:0] CIC_OFS_SH_BSR = 8'h18;
   localparam logic [7:0] CIC_OFS_SH_F0L = 8'h1C;
   localparam logic [7:0] CIC_OFS_SH_F0H = 8'h20;
   localparam logic [7:0] CIC_OFS_SH_F1L = 8'h24;
   localparam logic [7:0] CIC_OFS_SH_F1H = 8'h28;
   localparam logic [7:0] CIC_OFS_SH_PCL = 8'h2C;
   localparam logic [7:0] CIC_OFS_STATE  = 8'h30;
   // core control bit positions
   localparam int CIC_B_GIE  = 7;
   localparam int CIC_B_PERIPH_GROUP_ENABLE = 6;
   localparam int CIC_B_T0IE = 5;
   localparam int CIC_B_EXIE = 4;
   localparam int CIC_B_PCIE = 3;
   localparam int CIC_B_T0IF = 2;
   localparam int CIC_B_EXIF = 1;
   localparam int CIC_B_PCIF = 0;
   // status bits left alone by context save (timeout, powerdown)
   localparam logic [7:0] CIC_ST_KEEP_MASK = 8'h18;
   localparam logic [7:0] CIC_RST_REG      = 8'h00;
   localparam logic [15:0] CIC_VECTOR      = 16'h0004;
   // latency figures in instruction cycles
   localparam int CIC_LAT_SYNC_MIN  = 3;
   localparam int CIC_LAT_SYNC_MAX  = 4;
   localparam int CIC_LAT_ASYNC_MAX = 5;
   localparam int CIC_Q_PHASES      = 4;
   // shadow registers live in data bank 31
   localparam logic [4:0] CIC_SHADOW_BANK = 5'h1F;
endpackage

// [verification/cic_top_chk.sv]
// Purpose: port checks for the interrupt controller
// Assumes: one clock, synchronous active-high reset
// Notes:   live core registers stay steady, so shadows can be compared
`timescale 1ns/10ps
module cic_top_chk (
   // clock, reset and core inputs
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic        i_instr_done,
   input wire logic        i_return_from_interrupt,
   input wire logic [7:0]  i_live_w,
   input wire logic [7:0]  i_live_status,
   // controller outputs
   input wire logic        o_flush,
   input wire logic        o_push_pc,
   input wire logic        o_pop_pc,
   input wire logic        o_load_vector,
   input wire logic [15:0] o_vector,
   input wire logic        o_restore,
   input wire logic [7:0]  o_shadow_w,
   input wire logic [7:0]  o_shadow_status,
   input wire logic [4:0]  o_shadow_bank,
   input wire logic        o_irq_pending
);
   // single domain, so clock and disable are stated once
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   AST_RST_QUIET: assert property ($past(i_rst) |-> !o_irq_pending)
      else $error("request pending after reset");
   AST_ENTRY_CAUSE: assert property (
      o_flush |-> $past(o_irq_pending && i_instr_done)) else $error("entry without cause");
   AST_ENTRY_PUSH: assert property (o_flush |-> o_push_pc)
      else $error("flush without push");
   AST_ENTRY_VEC: assert property (o_flush |-> ##[1:12] o_load_vector)
      else $error("vector not loaded");
   AST_VEC_ADDR: assert property (o_load_vector |-> o_vector == 16'h0004)
      else $error("wrong vector");
   AST_RET: assert property (i_return_from_interrupt |=> o_pop_pc && o_restore)
      else $error("return not served");
   // status copy drops the timeout and powerdown bits
   AST_SAVE: assert property (o_load_vector |-> o_shadow_w == i_live_w &&
      o_shadow_status == (i_live_status & ~8'h18)) else $error("context not saved");
   AST_BANK: assert property (o_shadow_bank == 5'h1F)
      else $error("shadow bank wrong");
endmodule
bind cic_top cic_top_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_instr_done(i_instr_done), .i_return_from_interrupt(i_return_from_interrupt), .i_live_w(i_live_w),
   .i_live_status(i_live_status), .o_flush(o_flush), .o_push_pc(o_push_pc),
   .o_pop_pc(o_pop_pc), .o_load_vector(o_load_vector), .o_vector(o_vector),
   .o_restore(o_restore), .o_shadow_w(o_shadow_w), .o_shadow_status(o_shadow_status),
   .o_shadow_bank(o_shadow_bank), .o_irq_pending(o_irq_pending));

// [verification/cic_core_model.sv]
// Purpose: core stand-in pacing instructions and issuing returns
// Assumes: a boundary every four clocks, none while asleep
// Notes:   live registers are constants so shadow copies are predictable
`timescale 1ns/10ps
module cic_core_model (
   // clock, reset and firmware controls
   input  wire logic  i_clk_sys,
   input  wire logic  i_rst,
   input  wire logic  i_sleep,
   input  wire logic  i_ret_req,
   // toward the controller
   output logic       o_instr_done,
   output logic       o_return_from_interrupt,
   output logic [7:0] o_live_w,
   output logic [7:0] o_live_status
);
   logic [1:0] phase;
   // timeout and powerdown set so the save mask matters
   assign o_live_w      = 8'h5A;
   assign o_live_status = 8'h1F;
   // stopped clock in sleep means no boundaries
   always_ff @(posedge i_clk_sys) begin
      phase        <= (i_rst || i_sleep) ? 2'h0 : phase + 2'h1;
      o_instr_done <= !i_rst && !i_sleep && phase == 2'h3;
      o_return_from_interrupt     <= !i_rst && i_ret_req; // one clock after the firmware request, none during reset
   end
endmodule

// [verification/tb.sv]
// Purpose: self-checking bench for the interrupt controller
// Assumes: zero-wait apb slave, core model paces boundaries
// Notes:   the bench plays firmware through apb
`timescale 1ns/10ps
module tb import cic_pkg::*;;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cic_row_t;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready;
   logic        t0 = 1'b0, ext = 1'b0, pca = 1'b0, slp = 1'b0, retq = 1'b0;
   logic        done, ret, ldv, rest, wake, irq;
   logic [7:0]  paddr = 8'h00, pcf = 8'h00, pev = 8'h00, lw, ls, sw, sst;
   logic [31:0] pwdata = 32'h0, prdata, q;
   int          err_total = 0, check_count = 0;
   cic_row_t    rows [6] = '{'{CIC_OFS_PERIPHERAL_ENABLE_ONE, 32'hFF, 32'hFF}, '{CIC_OFS_CORE, 32'h78, 32'h78},
      '{CIC_OFS_CORE, 32'h07, 32'h06}, '{CIC_OFS_SH_W, 32'hA5, 32'hA5},
      '{CIC_OFS_OPTION, 32'h01, 32'h01}, '{8'h3C, 32'hFF, 32'h00}};
   always #50 clk = ~clk;
   cic_core_model u_core (.i_clk_sys(clk), .i_rst(rst), .i_sleep(slp), .i_ret_req(retq),
      .o_instr_done(done), .o_return_from_interrupt(ret), .o_live_w(lw), .o_live_status(ls));
   cic_top DUT (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(),
      .i_timer0_ovf(t0), .i_ext_pin(ext), .i_pin_change_flags(pcf), .i_periph_events(pev),
      .i_periph_wake_capable(8'h00), .i_pin_change_async(pca), .i_instr_done(done),
      .i_sleeping(slp), .i_return_from_interrupt(ret), .i_live_w(lw), .i_live_status(ls), .i_live_bsr(8'h03),
      .i_live_fsr0(16'h1234), .i_live_fsr1(16'h4321), .i_live_pc_high_latch(8'h02), .o_q_phase1(),
      .o_flush(), .o_push_pc(), .o_pop_pc(), .o_load_vector(ldv), .o_vector(),
      .o_restore(rest), .o_shadow_w(sw), .o_shadow_status(sst), .o_shadow_bsr(),
      .o_shadow_fsr0(), .o_shadow_fsr1(), .o_shadow_pc_high_latch(), .o_shadow_bank(), .o_wake(wake),
      .o_irq_pending(irq));
   task automatic test_done(input bit hang);
      if (hang) err_total++;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until pready is seen at an edge; a spare cycle avoids double drives
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) test_done(1'b1);
      q = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(q, e);
   endtask
   task automatic await(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) test_done(1'b1);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      // mid-run reset drops the enables written above
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(CIC_OFS_CORE, 32'h0);
      rd_chk(CIC_OFS_PERIPHERAL_ENABLE_ONE, 32'h0);
      t0 <= 1'b1;
      @(posedge clk);
      t0 <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(CIC_OFS_CORE, 32'h04);
      apb(1'b1, CIC_OFS_CORE, 32'h0);
      pcf <= 8'h01;
      apb(1'b1, CIC_OFS_CORE, 32'h0);
      rd_chk(CIC_OFS_CORE, 32'h01);
      pcf <= 8'h00;
      repeat (2) @(posedge clk);
      rd_chk(CIC_OFS_CORE, 32'h0);
      // both edge selects against both pin edges
      for (int i = 0; i < 4; i++) begin
         ext <= i[0] ^ i[1];
         apb(1'b1, CIC_OFS_OPTION, {31'h0, !i[0]});
         apb(1'b1, CIC_OFS_CORE, 32'h0);
         ext <= !(i[0] ^ i[1]);
         repeat (8) @(posedge clk);
         rd_chk(CIC_OFS_CORE, i[1] ? 32'h0 : 32'h02);
      end
      apb(1'b1, CIC_OFS_PFLAG, 32'h0); // stale flag cleared before enabling
      apb(1'b1, CIC_OFS_PERIPHERAL_ENABLE_ONE, 32'h01);
      apb(1'b1, CIC_OFS_CORE, 32'h80);
      pev <= 8'h01;
      @(posedge clk);
      pev <= 8'h00;
      repeat (8) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, CIC_OFS_CORE, 32'hC0);
      await(ldv);
      check({24'h0, sst}, 32'h07);
      rd_chk(CIC_OFS_CORE, 32'h40);
      rd_chk(CIC_OFS_PFLAG, 32'h01);
      apb(1'b1, CIC_OFS_SH_W, 32'h3C);
      apb(1'b1, CIC_OFS_PFLAG, 32'h0);
      retq <= 1'b1;
      @(posedge clk);
      retq <= 1'b0;
      await(rest);
      check({24'h0, sw}, 32'h3C);
      rd_chk(CIC_OFS_CORE, 32'hC0);
      apb(1'b1, CIC_OFS_CORE, 32'h08); // enable set before sleeping
      pca <= 1'b1;
      pcf <= 8'h01;
      slp <= 1'b1;
      await(wake);
      slp <= 1'b0;
      test_done(1'b0);
   end
endmodule
